// file: rtl/lpsdc_core.sv
// Functional notes
// - 192-bit pwm_level shift register and latch
// - Blanking high forces every sink off
// - On-time equals count period times value
// - Strobe updates pwm_level latch immediately
// - Select low: shift pwm_level MSB first
// - Strobe rise copies pwm_level shift register
// - 96-bit current_trim register and latch, 6-bit
// - Select high: shift current_trim MSB first
// - Strobe rise, select high: latch current_trim
// - 18-bit status_word shifts out serially
// - First clock after strobe falls loads status
// - Low 174 bits untouched by status load
// - Open flags update at 33rd count edge
// - Open flag checked only for lit channels
// - Values below 21h miss open LED
// - Overtemp flag set when drivers forced off
// - Warning flag set without forcing drivers off
// - Counter held zero while blanked, then counts
// - Nonzero channel on at first edge, off after
// - Overtemp latches off until next blank fall
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`include "lpsdc_defines.svh"

module lpsdc_core
  import lpsdc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        serial_clk,
  input  wire logic        serial_data_in,
  input  wire logic        latch_strobe,
  input  wire logic        correction_select,
  input  wire logic        blank,
  input  wire logic        pwm_count_clock,
  input  wire logic [15:0] open_led_sense,
  input  wire logic        overtemp_sense,
  input  wire logic        heat_warning_sense,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             serial_data_out,
  output logic      [15:0] sink_on,
  output logic      [95:0] current_trim
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Extracts the 12-bit channel_pwm_value of one channel from a 192-bit image.
  function automatic logic [11:0] chan_val(input logic [191:0] img, input int ch);
    chan_val = img[ch*`LPSDC_PWM_BITS +: `LPSDC_PWM_BITS];
  endfunction

  // Tells whether a channel is lit for a given counter value.
  function automatic logic chan_lit(input logic [12:0] cnt, input logic [11:0] val);
    chan_lit = (cnt != 13'h0000) && (cnt <= {1'b0, val});
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  lpsdc_pins_t pins_meta_q;
  lpsdc_pins_t pins_q;
  lpsdc_pins_t pins_prev_q;
  logic [17:0] sense_meta_q;
  logic [17:0] sense_q;

  // Two flops per pin; only the second stage is read by logic.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pins_meta_q  <= '0;
      pins_q       <= '0;
      sense_meta_q <= 18'h00000;
      sense_q      <= 18'h00000;
    end
    else
    begin
      pins_meta_q  <= {serial_clk, serial_data_in, latch_strobe,
                       correction_select, blank, pwm_count_clock};
      pins_q       <= pins_meta_q;
      sense_meta_q <= {heat_warning_sense, overtemp_sense, open_led_sense};
      sense_q      <= sense_meta_q;
    end
  end

  // Edge detector history, fed from the second synchroniser stage.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pins_prev_q <= '0;
    end
    else
    begin
      pins_prev_q <= pins_q;
    end
  end

  logic sclk_rise;
  logic strobe_rise;
  logic strobe_fall;
  logic count_rise;
  logic blank_eff;
  logic ctrl_blank_q;

  // Edge pulses and effective blanking, including the software blank bit.
  assign sclk_rise   = pins_q.serial_clk & ~pins_prev_q.serial_clk;
  assign strobe_rise = pins_q.latch_strobe & ~pins_prev_q.latch_strobe;
  assign strobe_fall = ~pins_q.latch_strobe & pins_prev_q.latch_strobe;
  assign count_rise  = pins_q.pwm_count_clock & ~pins_prev_q.pwm_count_clock;
  assign blank_eff   = pins_q.blank | ctrl_blank_q;

  // --------------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------------
  lpsdc_status_t status_word;
  logic [15:0]   open_led_flag_q;

  // Thermal flags follow their sensors directly.
  assign status_word.heat_warning_flag = sense_q[17];
  assign status_word.overtemp_flag     = sense_q[16];
  assign status_word.open_led_flag     = open_led_flag_q;

  // --------------------------------------------------------------------------
  // Shift registers
  // --------------------------------------------------------------------------
  logic [191:0] pwm_sr_q;
  logic [95:0]  trim_sr_q;
  logic         status_pending_q;

  // A falling strobe arms the status load for the next serial clock edge.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      status_pending_q <= 1'b0;
    end
    else if (strobe_fall)
    begin
      status_pending_q <= 1'b1;
    end
    else if (sclk_rise)
    begin
      status_pending_q <= 1'b0;
    end
  end

  // The pwm_level shift register shifts MSB first, or takes the status word.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pwm_sr_q <= '0;
    end
    else if (sclk_rise && status_pending_q)
    begin
      pwm_sr_q[191:`LPSDC_PWM_SR_LOW] <= status_word;
    end
    else if (sclk_rise && !pins_q.correction_select)
    begin
      pwm_sr_q <= {pwm_sr_q[190:0], pins_q.serial_data_in};
    end
  end

  // The current_trim shift register shifts MSB first while select is high.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      trim_sr_q <= '0;
    end
    else if (sclk_rise && pins_q.correction_select)
    begin
      trim_sr_q <= {trim_sr_q[94:0], pins_q.serial_data_in};
    end
  end

  // Serial output carries the MSB of the register in use for daisy chaining.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      serial_data_out <= 1'b0;
    end
    else if (pins_q.correction_select)
    begin
      serial_data_out <= trim_sr_q[95];
    end
    else
    begin
      serial_data_out <= pwm_sr_q[191];
    end
  end

  // --------------------------------------------------------------------------
  // Latches
  // --------------------------------------------------------------------------
  logic [191:0] pwm_latch_q;

  // The pwm_level latch updates at once, even mid display period.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pwm_latch_q <= '0;
    end
    else if (strobe_rise && !pins_q.correction_select)
    begin
      pwm_latch_q <= pwm_sr_q;
    end
  end

  // The current_trim latch loads only with select high.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      current_trim <= '0;
    end
    else if (strobe_rise && pins_q.correction_select)
    begin
      current_trim <= trim_sr_q;
    end
  end

  // --------------------------------------------------------------------------
  // PWM counter and thermal cutoff
  // --------------------------------------------------------------------------
  logic [12:0] pwm_cnt_q;
  logic [12:0] pwm_cnt_next;
  logic        thermal_cutoff_q;

  // Next counter value; saturates past the top code so no channel relights.
  assign pwm_cnt_next = (pwm_cnt_q == `LPSDC_PWM_CNT_MAX) ? pwm_cnt_q : pwm_cnt_q + 13'h0001;

  // Counter held at zero while blanked, counts count clock edges otherwise.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pwm_cnt_q <= 13'h0000;
    end
    else if (blank_eff)
    begin
      pwm_cnt_q <= 13'h0000;
    end
    else if (count_rise)
    begin
      pwm_cnt_q <= pwm_cnt_next;
    end
  end

  // Cutoff latches on overtemp and releases only while blanked and cool.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      thermal_cutoff_q <= 1'b0;
    end
    else if (status_word.overtemp_flag)
    begin
      thermal_cutoff_q <= 1'b1;
    end
    else if (blank_eff)
    begin
      thermal_cutoff_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Sink drive and open-LED detection
  // --------------------------------------------------------------------------
  logic [15:0] lit;

  // A channel is lit from count 1 until the count passes its value.
  always_comb
  begin
    for (int ch = 0; ch < `LPSDC_CHANNELS; ch++)
    begin
      lit[ch] = chan_lit(pwm_cnt_q, chan_val(pwm_latch_q, ch));
    end
  end

  // Sinks are forced off while blanked or in thermal cutoff.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sink_on <= 16'h0000;
    end
    else if (blank_eff || thermal_cutoff_q || status_word.overtemp_flag)
    begin
      sink_on <= 16'h0000;
    end
    else
    begin
      sink_on <= lit;
    end
  end

  // At the 33rd count edge, lit channels report their sense unless in thermal cutoff; others read zero.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      open_led_flag_q <= 16'h0000;
    end
    else if (count_rise && !blank_eff && pwm_cnt_next == `LPSDC_OPEN_SAMPLE)
    begin
      for (int ch = 0; ch < `LPSDC_CHANNELS; ch++)
      begin
        // Short values are already dark here and read zero.
        open_led_flag_q[ch] <= sense_q[ch] &&
          chan_lit(pwm_cnt_next, chan_val(pwm_latch_q, ch)) &&
          !thermal_cutoff_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Avalon-MM slave
  // --------------------------------------------------------------------------
  logic [1:0] reg_index;
  logic       req_take;

  // Each request is answered after one wait cycle.
  assign reg_index = avs_address[3:2];
  assign req_take  = (avs_read | avs_write) & avs_waitrequest;

  // Waitrequest drops for exactly one cycle per request.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= ~req_take;
    end
  end

  // Control register: bit 0 forces blanking from software.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_blank_q <= `LPSDC_CTRL_RESET;
    end
    else if (req_take && avs_write && reg_index == `LPSDC_REG_CTRL && avs_byteenable[0])
    begin
      ctrl_blank_q <= avs_writedata[`LPSDC_CTRL_BLANK];
    end
  end

  // Read data is registered; address bits 1:0 are ignored, so every offset reads one of the four registers.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (req_take && avs_read)
    begin
      case (reg_index)
        `LPSDC_REG_CTRL:   avs_readdata <= {31'h00000000, ctrl_blank_q};
        `LPSDC_REG_STATUS: avs_readdata <= {14'h0000, status_word};
        `LPSDC_REG_COUNT:  avs_readdata <= {19'h00000, pwm_cnt_q};
        `LPSDC_REG_SINKS:  avs_readdata <= {15'h0000, thermal_cutoff_q, sink_on};
        default:           avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// file: rtl/lpsdc_defines.svh
`ifndef LPSDC_DEFINES_SVH
`define LPSDC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define LPSDC_CHANNELS      16
`define LPSDC_PWM_BITS      12
`define LPSDC_PWM_SR_BITS   192
`define LPSDC_TRIM_BITS     6
`define LPSDC_TRIM_SR_BITS  96
`define LPSDC_STATUS_BITS   18
`define LPSDC_PWM_SR_LOW    174

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define LPSDC_OPEN_SAMPLE   13'h0021
`define LPSDC_PWM_CNT_MAX   13'h1000

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define LPSDC_REG_CTRL      2'h0
`define LPSDC_REG_STATUS    2'h1
`define LPSDC_REG_COUNT     2'h2
`define LPSDC_REG_SINKS     2'h3
`define LPSDC_CTRL_BLANK    0
`define LPSDC_CTRL_RESET    1'h0

`endif

// file: rtl/lpsdc_pkg.sv
package lpsdc_pkg;

  // Status word as it is loaded into the top of the pwm_level shift register.
  typedef struct packed {
    logic        heat_warning_flag;
    logic        overtemp_flag;
    logic [15:0] open_led_flag;
  } lpsdc_status_t;

  // Serial interface pins after synchronisation.
  typedef struct packed {
    logic serial_clk;
    logic serial_data_in;
    logic latch_strobe;
    logic correction_select;
    logic blank;
    logic pwm_count_clock;
  } lpsdc_pins_t;

endpackage

// file: testbench/lpsdc_host.sv
`timescale 1ns/1ns
module lpsdc_host
(
  input  wire logic core_clk,
  input  wire logic serial_data_out,
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      latch_strobe,
  output logic      correction_select,
  output logic      blank,
  output logic      pwm_count_clock
);
  logic [191:0] rd;

  // Pins start idle and the sinks stay blanked until both latches hold data.
  initial
  begin
    {serial_clk, serial_data_in, latch_strobe, correction_select, pwm_count_clock} = 5'h00;
    blank = 1'b1;
  end

  // Shifts n bits MSB first on an 80 ns link clock and records the serial output.
  task automatic shift(input logic [191:0] d, input int n, input logic sel);
    correction_select <= sel;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data_in <= d[i];
      repeat (5) @(posedge core_clk);
      rd[i] = serial_data_out;
      serial_clk <= 1'b1;
      repeat (5) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    serial_data_in <= ~d[0];  // A released data line must not look like valid data.
  endtask

  // Pulses the strobe; select stays put for well over 100 ns after the rise.
  task automatic strobe();
    latch_strobe <= 1'b1;
    repeat (13) @(posedge core_clk);
    latch_strobe <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask

  // Sets the blanking level; new data is only strobed in while blanked.
  task automatic set_blank(input logic v);
    blank <= v;
    repeat (4) @(posedge core_clk);
  endtask

  // Gives n count clock pulses of eight core cycles each.
  task automatic count(input int n);
    repeat (n)
    begin
      pwm_count_clock <= 1'b1;
      repeat (4) @(posedge core_clk);
      pwm_count_clock <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule

// file: testbench/lpsdc_chk.sv
`timescale 1ns/1ns
module lpsdc_chk
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        serial_clk,
  input wire logic        latch_strobe,
  input wire logic        correction_select,
  input wire logic        blank,
  input wire logic        pwm_count_clock,
  input wire logic        overtemp_sense,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        serial_data_out,
  input wire logic [15:0] sink_on,
  input wire logic [95:0] current_trim
);
  // All checks run on the core clock and rest during reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Outputs must follow their causes at the pins.
  a_blank_forces_off: assert property (blank [*6] |-> sink_on == 16'h0000)
    else $error("sinks on while blanked");
  a_hot_forces_off: assert property (overtemp_sense [*6] |-> sink_on == 16'h0000)
    else $error("sinks on while overheated");
  a_cutoff_holds: assert property ($fell(overtemp_sense) |-> (sink_on == 16'h0000) [*8])
    else $error("sinks resumed before next blank");
  a_sink_has_cause: assert property (
    $stable({pwm_count_clock, blank, overtemp_sense, latch_strobe, avs_write}) [*8]
    |=> $stable(sink_on))
    else $error("sinks moved without a cause");
  a_out_has_cause: assert property (
    $stable({serial_clk, correction_select}) [*8] |=> $stable(serial_data_out))
    else $error("serial out moved without a clock");
  a_trim_needs_strobe: assert property (!latch_strobe [*6] |=> $stable(current_trim))
    else $error("trim latch moved without strobe");
  a_trim_needs_select: assert property (!correction_select [*6] |=> $stable(current_trim))
    else $error("trim latch moved with select low");
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  // Main scenarios seen.
  c_trim_loaded: cover property ($changed(current_trim));
  c_sink_lit: cover property ($rose(sink_on[15]));
  c_hot_cut: cover property ($fell(overtemp_sense));
endmodule

bind lpsdc_core lpsdc_chk u_lpsdc_chk (.*);

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
  import lpsdc_pkg::*;
  logic          core_clk, rst, serial_clk, serial_data_in, latch_strobe, correction_select;
  logic          blank, pwm_count_clock, serial_data_out, overtemp_sense, heat_warning_sense;
  logic          avs_read, avs_write, avs_waitrequest;
  logic [3:0]    avs_address, avs_byteenable, be_mask;
  logic [15:0]   open_led_sense, sink_on;
  logic [31:0]   avs_writedata, avs_readdata, rdata;
  logic [95:0]   current_trim, trim;
  logic [191:0]  pwm_sr;
  lpsdc_status_t st;
  int            fails, n_compared, seed, on_n[16];

  lpsdc_core u_lpsdc_core (.*);
  lpsdc_host u_lpsdc_host (.*);

  // Free-running core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [191:0] e, g);
    n_compared++;
    if (e !== g)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus access, held until waitrequest is seen low.
  // Read data and unused lanes carry noise; only the watchdog ends a wait.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wr ? d : $random(seed);
    avs_byteenable <= (4'($random(seed)) | 4'h1) & be_mask;
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  // Mask of channels whose value is at least c.
  function automatic logic [15:0] lit(input logic [191:0] p, input logic [11:0] c);
    for (int n = 0; n < 16; n++)
      lit[n] = p[12*n +: 12] >= c;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hung run short.
  initial
  begin
    #600000;
    fails++;
    wrap_up();
  end

  // Trim load, pwm load and full cycle, status readout, overheat, soft blank.
  initial
  begin
    seed = 32'h03fd2623;
    be_mask = 4'hf;
    rst = 1'b1;
    {avs_read, avs_write, overtemp_sense, heat_warning_sense} = 4'h1;
    {avs_address, avs_byteenable, avs_writedata} = '0;
    open_led_sense = 16'($random(seed));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    trim = {$random(seed), $random(seed), $random(seed)};
    u_lpsdc_host.shift(192'(trim), 96, 1'b1);
    u_lpsdc_host.strobe();
    chk("trim", 192'(trim), 192'(current_trim));
    // The first serial edge after a strobe loads status, so a spare edge goes first.
    u_lpsdc_host.shift(192'(0), 1, 1'b0);
    for (int n = 0; n < 16; n++)
      pwm_sr[12*n +: 12] = (n < 2) ? 12'(n) : 12'($random(seed)) & 12'h07f;
    pwm_sr[47:24] = 24'h021020;
    pwm_sr[191:180] = 12'hfff;
    u_lpsdc_host.shift(pwm_sr, 192, 1'b0);
    u_lpsdc_host.strobe();
    u_lpsdc_host.count(3);
    bus(1'b0, 4'h8, 32'h0);
    chk("count blanked", 192'(0), 192'(rdata));
    chk("sinks blanked", 192'(0), 192'(sink_on));
    u_lpsdc_host.set_blank(1'b0);
    st = {2'b10, open_led_sense & lit(pwm_sr, 12'h021)};
    for (int k = 1; k <= 4100; k++)
    begin
      u_lpsdc_host.count(1);
      for (int n = 0; n < 16; n++)
        on_n[n] += int'(sink_on[n]);
      if (k == 40)
      begin
        bus(1'b0, 4'h4, 32'h0);
        chk("status reg", 192'(st), 192'(rdata[17:0]));
        bus(1'b0, 4'h8, 32'h0);
        chk("count", 192'(40), 192'(rdata));
        open_led_sense <= 16'($random(seed));
      end
    end
    for (int n = 0; n < 16; n++)
      chk("on time", 192'(pwm_sr[12*n +: 12]), 192'(on_n[n]));
    u_lpsdc_host.set_blank(1'b1);
    u_lpsdc_host.shift({6{$random(seed)}}, 192, 1'b0);
    chk("status out", 192'(st), 192'(u_lpsdc_host.rd[190:173]));
    chk("first out", 192'(pwm_sr[191]), 192'(u_lpsdc_host.rd[191]));
    chk("kept bits", 192'(pwm_sr[173:1]), 192'(u_lpsdc_host.rd[172:0]));
    u_lpsdc_host.set_blank(1'b0);
    u_lpsdc_host.count(2);
    overtemp_sense <= 1'b1;
    heat_warning_sense <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("hot sinks", 192'(0), 192'(sink_on));
    bus(1'b0, 4'h4, 32'h0);
    chk("hot flags", 192'(2'b01), 192'(rdata[17:16]));
    overtemp_sense <= 1'b0;
    u_lpsdc_host.count(3);
    chk("cooled sinks", 192'(0), 192'(sink_on));
    u_lpsdc_host.set_blank(1'b1);
    u_lpsdc_host.set_blank(1'b0);
    u_lpsdc_host.count(1);
    chk("restart", 192'(lit(pwm_sr, 12'h001)), 192'(sink_on));
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl", 192'(1), 192'(rdata[0]));
    repeat (3) @(posedge core_clk);
    chk("soft blank", 192'(0), 192'(sink_on));
    be_mask = 4'he;
    bus(1'b1, 4'h0, 32'h0);
    be_mask = 4'hf;
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl kept", 192'(1), 192'(rdata[0]));
    heat_warning_sense <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk("warm flag", 192'(1), 192'(rdata[17]));
    // A warm host clears the top bit of every trim setting before reloading it.
    trim = trim & {16{6'h1f}};
    u_lpsdc_host.shift(192'(trim), 96, 1'b1);
    u_lpsdc_host.strobe();
    chk("trim lowered", 192'(trim), 192'(current_trim));
    wrap_up();
  end
endmodule
